// ---- verilog/serial_map.svh ----
// register offsets, field positions, reset values and counts of the serial unit
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
`define ADDR_FORMAT 3'h0
`define ADDR_CTRL 3'h1
`define ADDR_TXDATA 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_RXDATA 3'h4
`define ADDR_MASK 3'h5
`define FORMAT_RESET 8'h00
`define CTRL_RESET 8'h00
`define TXDATA_RESET 8'hFF
`define RXDATA_RESET 8'h00
`define STATUS_RESET 8'h84
`define MASK_RESET 8'h00
`define CTRL_TIE 7
`define CTRL_RIE 6
`define ST_TX_HOLDING_EMPTY 7
`define ST_RX_HOLDING_FULL 6
`define ST_OER 5
`define ST_FER 4
`define ST_PER 3
`define ST_TEND 2
`define ST_MPBR 1
`define ST_MPBT 0
`define W1C_BITS 8'h78
`define PSC_16_LAST 4'hF
`define PSC_64_LAST 6'h3F
`define BRG_LAST 8'h01
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define HALF_BIT 4'h8
`endif

// ---- verilog/serial_pkg.sv ----
// types shared by the serial format and control unit
package serial_pkg;
  typedef struct packed {
    logic mode_sync;
    logic char_length_select;
    logic parity_enable;
    logic parity_odd_select;
    logic stop_two;
    logic multiprocessor_enable;
    logic baud_prescale_sel_hi;
    logic baud_prescale_sel_lo;
  } fmt_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } bus_req_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_type;
endpackage

// ---- verilog/serial_unit.sv ----
// serial unit with format and control registers, transmitter and receiver
`timescale 1ns/10ps
`include "serial_map.svh"

module serial_unit
  import serial_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input bus_req_type bus_req,
  output logic [7:0] rd_data,
  // power mode inputs
  input wire logic standby_req,
  input wire logic sub_mode,
  input wire logic sub_clk,
  // serial pins
  input wire logic rxd,
  output logic txd,
  output logic serial_clk_out,
  // interrupts
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic irq
);
  logic rst_meta_reg, rst_sync_reg;
  logic rxd_meta_reg, rxd_sync_reg;
  logic sub_meta_reg, sub_sync_reg, sub_prev_reg, sub_half_reg;
  fmt_type format_reg, tx_cfg_reg, rx_cfg_reg;
  logic [7:0] ctrl_reg, tx_holding_reg, rx_holding_reg, mask_reg, rd_data_reg;
  logic tx_holding_empty_reg, rx_holding_full_reg, oer_reg, fer_reg, per_reg, tend_reg, mpbr_reg, mpbt_reg;
  logic [7:0] status_vec;
  logic [5:0] psc_cnt_reg;
  logic [7:0] brg_cnt_reg;
  logic prescale_tick, sample_tick_reg, sub_edge;
  tx_state_type tx_state_reg;
  rx_state_type rx_state_reg;
  logic [3:0] tx_cnt_reg, rx_cnt_reg;
  logic [2:0] tx_idx_reg, rx_idx_reg;
  logic [7:0] tx_shifter, rx_shifter, tx_masked, rx_data;
  logic tx_extra_reg, tx_second_reg, rx_extra_reg, rx_stop_bad_reg, rx_done_reg;
  logic txd_reg, sclk_reg, txe_irq_reg, rxf_irq_reg, rxe_irq_reg, irq_reg;
  logic wr_fmt, wr_ctrl, wr_tx, wr_st, wr_mask, load_pulse, tx_end, sync_rise;
  logic [7:0] st_clr;
  logic rx_holding_full_set, oer_set, err_clr;

  function automatic logic [2:0] last_bit(input fmt_type f);
    if (f.mode_sync) begin
      last_bit = 3'h7;
    end else if (f.parity_enable && f.multiprocessor_enable) begin
      last_bit = 3'h4;
    end else if (f.char_length_select) begin
      last_bit = 3'h6;
    end else begin
      last_bit = 3'h7;
    end
  endfunction

  function automatic logic has_extra(input fmt_type f);
    has_extra = !f.mode_sync && (f.parity_enable ^ f.multiprocessor_enable);
  endfunction

  // reset release and pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      sub_meta_reg <= 1'b0;
      sub_sync_reg <= 1'b0;
      sub_prev_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
      sub_meta_reg <= sub_clk;
      sub_sync_reg <= sub_meta_reg;
      sub_prev_reg <= sub_sync_reg;
    end
  end

  assign wr_fmt = bus_req.wr && bus_req.addr == `ADDR_FORMAT;
  assign wr_ctrl = bus_req.wr && bus_req.addr == `ADDR_CTRL;
  assign wr_tx = bus_req.wr && bus_req.addr == `ADDR_TXDATA;
  assign wr_st = bus_req.wr && bus_req.addr == `ADDR_STATUS;
  assign wr_mask = bus_req.wr && bus_req.addr == `ADDR_MASK;
  assign st_clr = wr_st ? (bus_req.data & `W1C_BITS) : 8'h00;

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      format_reg <= `FORMAT_RESET;
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
    end else if (standby_req) begin
      format_reg <= `FORMAT_RESET;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      if (wr_fmt) begin
        format_reg <= bus_req.data;
      end
      if (wr_ctrl) begin
        ctrl_reg <= bus_req.data;
      end
      if (wr_mask) begin
        mask_reg <= bus_req.data;
      end
    end
  end

  // baud prescaler and 16x sample tick
  assign sub_edge = sub_sync_reg && !sub_prev_reg;
  always_comb begin
    case ({format_reg.baud_prescale_sel_hi, format_reg.baud_prescale_sel_lo})
      2'b00: prescale_tick = 1'b1;
      2'b01: prescale_tick = sub_edge && (sub_mode || sub_half_reg);
      2'b10: prescale_tick = psc_cnt_reg[3:0] == `PSC_16_LAST;
      2'b11: prescale_tick = psc_cnt_reg == `PSC_64_LAST;
      default: prescale_tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      psc_cnt_reg <= 6'h00;
      brg_cnt_reg <= 8'h00;
      sub_half_reg <= 1'b0;
      sample_tick_reg <= 1'b0;
    end else begin
      psc_cnt_reg <= psc_cnt_reg + 6'h01;
      if (sub_edge) begin
        sub_half_reg <= !sub_half_reg;
      end
      sample_tick_reg <= 1'b0;
      if (prescale_tick) begin
        if (brg_cnt_reg == `BRG_LAST) begin
          brg_cnt_reg <= 8'h00;
          sample_tick_reg <= 1'b1;
        end else begin
          brg_cnt_reg <= brg_cnt_reg + 8'h01;
        end
      end
    end
  end

  // transmitter
  always_comb begin
    tx_masked = tx_holding_reg;
    if (!format_reg.mode_sync) begin
      if (format_reg.parity_enable && format_reg.multiprocessor_enable) begin
        tx_masked = tx_holding_reg & 8'h1F;
      end else if (format_reg.char_length_select) begin
        tx_masked = tx_holding_reg & 8'h7F;
      end
    end
  end

  assign load_pulse = tx_state_reg == TX_IDLE && !tx_holding_empty_reg && !wr_tx && !standby_req;
  assign tx_end = sample_tick_reg && tx_cnt_reg == `OVS_LAST &&
    ((tx_state_reg == TX_STOP && (!tx_cfg_reg.stop_two || tx_second_reg)) ||
     (tx_state_reg == TX_DATA && tx_cfg_reg.mode_sync && tx_idx_reg == 3'h7));

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 4'h0;
      tx_idx_reg <= 3'h0;
      tx_shifter <= 8'h00;
      tx_cfg_reg <= `FORMAT_RESET;
      tx_extra_reg <= 1'b0;
      tx_second_reg <= 1'b0;
    end else if (standby_req) begin
      tx_state_reg <= TX_IDLE;
    end else if (load_pulse) begin
      tx_shifter <= tx_masked;
      tx_cfg_reg <= format_reg;
      tx_cnt_reg <= 4'h0;
      tx_idx_reg <= 3'h0;
      tx_second_reg <= 1'b0;
      if (format_reg.multiprocessor_enable) begin
        tx_extra_reg <= mpbt_reg;
      end else begin
        tx_extra_reg <= ^tx_masked ^ format_reg.parity_odd_select;
      end
      tx_state_reg <= format_reg.mode_sync ? TX_DATA : TX_START;
    end else if (sample_tick_reg && tx_state_reg != TX_IDLE) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == `OVS_LAST) begin
        case (tx_state_reg)
          TX_START: tx_state_reg <= TX_DATA;
          TX_DATA: begin
            tx_shifter <= {1'b0, tx_shifter[7:1]};
            tx_idx_reg <= tx_idx_reg + 3'h1;
            if (tx_idx_reg == last_bit(tx_cfg_reg)) begin
              if (tx_cfg_reg.mode_sync) begin
                tx_state_reg <= TX_IDLE;
              end else if (has_extra(tx_cfg_reg)) begin
                tx_state_reg <= TX_EXTRA;
              end else begin
                tx_state_reg <= TX_STOP;
              end
            end
          end
          TX_EXTRA: tx_state_reg <= TX_STOP;
          TX_STOP: begin
            if (tx_cfg_reg.stop_two && !tx_second_reg) begin
              tx_second_reg <= 1'b1;
            end else begin
              tx_state_reg <= TX_IDLE;
            end
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      txd_reg <= 1'b1;
      sclk_reg <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_START: txd_reg <= 1'b0;
        TX_DATA: txd_reg <= tx_shifter[0];
        TX_EXTRA: txd_reg <= tx_extra_reg;
        TX_STOP: txd_reg <= 1'b1;
        default: txd_reg <= 1'b1;
      endcase
      sclk_reg <= !(tx_cfg_reg.mode_sync && tx_state_reg == TX_DATA &&
        tx_cnt_reg < `HALF_BIT);
    end
  end

  // receiver
  assign sync_rise = tx_cfg_reg.mode_sync && tx_state_reg == TX_DATA &&
    sample_tick_reg && tx_cnt_reg == `OVS_MID;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_shifter <= 8'h00;
      rx_cfg_reg <= `FORMAT_RESET;
      rx_extra_reg <= 1'b0;
      rx_stop_bad_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (standby_req) begin
        rx_state_reg <= RX_IDLE;
      end else if (format_reg.mode_sync) begin
        rx_state_reg <= RX_IDLE;
        if (sync_rise) begin
          rx_cfg_reg <= tx_cfg_reg;
          rx_shifter <= {rxd_sync_reg, rx_shifter[7:1]};
          rx_extra_reg <= 1'b0;
          rx_stop_bad_reg <= 1'b0;
          rx_done_reg <= tx_idx_reg == 3'h7;
        end
      end else if (sample_tick_reg) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE: begin
            rx_cnt_reg <= 4'h0;
            if (!rxd_sync_reg) begin
              rx_state_reg <= RX_START;
              rx_cfg_reg <= format_reg;
            end
          end
          RX_START: begin
            if (rx_cnt_reg == `OVS_MID) begin
              rx_cnt_reg <= 4'h0;
              rx_idx_reg <= 3'h0;
              rx_state_reg <= rxd_sync_reg ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_cnt_reg == `OVS_LAST) begin
              rx_shifter <= {rxd_sync_reg, rx_shifter[7:1]};
              rx_idx_reg <= rx_idx_reg + 3'h1;
              if (rx_idx_reg == last_bit(rx_cfg_reg)) begin
                rx_state_reg <= has_extra(rx_cfg_reg) ? RX_EXTRA : RX_STOP;
              end
            end
          end
          RX_EXTRA: begin
            if (rx_cnt_reg == `OVS_LAST) begin
              rx_extra_reg <= rxd_sync_reg;
              rx_state_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_cnt_reg == `OVS_LAST) begin
              rx_stop_bad_reg <= !rxd_sync_reg;
              rx_done_reg <= 1'b1;
              rx_state_reg <= RX_IDLE;
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    rx_data = rx_shifter;
    if (!rx_cfg_reg.mode_sync) begin
      if (rx_cfg_reg.parity_enable && rx_cfg_reg.multiprocessor_enable) begin
        rx_data = {3'h0, rx_shifter[7:3]};
      end else if (rx_cfg_reg.char_length_select) begin
        rx_data = {1'b0, rx_shifter[7:1]};
      end
    end
  end

  // status flags, set wins over clear except tend, which a transmit data write clears
  assign rx_holding_full_set = rx_done_reg && !rx_holding_full_reg;
  assign oer_set = rx_done_reg && rx_holding_full_reg;
  assign status_vec = {tx_holding_empty_reg, rx_holding_full_reg, oer_reg, fer_reg, per_reg, tend_reg,
    mpbr_reg, mpbt_reg};

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      {tx_holding_empty_reg, rx_holding_full_reg, oer_reg, fer_reg, per_reg, tend_reg, mpbr_reg,
        mpbt_reg} <= `STATUS_RESET;
      tx_holding_reg <= `TXDATA_RESET;
      rx_holding_reg <= `RXDATA_RESET;
    end else if (standby_req) begin
      {tx_holding_empty_reg, rx_holding_full_reg, oer_reg, fer_reg, per_reg, tend_reg, mpbr_reg,
        mpbt_reg} <= `STATUS_RESET;
      tx_holding_reg <= `TXDATA_RESET;
      rx_holding_reg <= `RXDATA_RESET;
    end else begin
      if (wr_tx) begin
        tx_holding_reg <= bus_req.data;
        tx_holding_empty_reg <= 1'b0;
        tend_reg <= 1'b0;
      end else begin
        tx_holding_empty_reg <= tx_holding_empty_reg || load_pulse;
        tend_reg <= tend_reg || (tx_end && tx_holding_empty_reg);
      end
      if (wr_st) begin
        mpbt_reg <= bus_req.data[`ST_MPBT];
      end
      rx_holding_full_reg <= (rx_holding_full_reg && !st_clr[`ST_RX_HOLDING_FULL]) || rx_holding_full_set;
      oer_reg <= (oer_reg && !st_clr[`ST_OER]) || oer_set;
      fer_reg <= (fer_reg && !st_clr[`ST_FER]) || (rx_holding_full_set && rx_stop_bad_reg);
      per_reg <= (per_reg && !st_clr[`ST_PER]) || (rx_holding_full_set &&
        rx_cfg_reg.parity_enable && !rx_cfg_reg.multiprocessor_enable &&
        !rx_cfg_reg.mode_sync &&
        ((^rx_data ^ rx_extra_reg) != rx_cfg_reg.parity_odd_select));
      if (rx_holding_full_set) begin
        rx_holding_reg <= rx_data;
        mpbr_reg <= rx_cfg_reg.multiprocessor_enable &&
          !rx_cfg_reg.parity_enable && rx_extra_reg;
      end
    end
  end

  // interrupt requests
  assign err_clr = |st_clr[`ST_OER:`ST_PER] || st_clr[`ST_RX_HOLDING_FULL];
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      txe_irq_reg <= 1'b0;
      rxf_irq_reg <= 1'b0;
      rxe_irq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      txe_irq_reg <= ctrl_reg[`CTRL_TIE] && tx_holding_empty_reg;
      rxf_irq_reg <= ctrl_reg[`CTRL_RIE] && !standby_req &&
        ((rxf_irq_reg && !err_clr) || rx_holding_full_set);
      rxe_irq_reg <= ctrl_reg[`CTRL_RIE] && (oer_reg || fer_reg || per_reg);
      irq_reg <= |(status_vec & mask_reg);
    end
  end

  // register read port
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rd_data_reg <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `ADDR_FORMAT: rd_data_reg <= format_reg;
        `ADDR_CTRL: rd_data_reg <= ctrl_reg;
        `ADDR_TXDATA: rd_data_reg <= tx_holding_reg;
        `ADDR_STATUS: rd_data_reg <= status_vec;
        `ADDR_RXDATA: rd_data_reg <= rx_holding_reg;
        `ADDR_MASK: rd_data_reg <= mask_reg;
        default: rd_data_reg <= 8'h00;
      endcase
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data = rd_data_reg;
  assign txd = txd_reg;
  assign serial_clk_out = sclk_reg;
  assign tx_empty_irq = txe_irq_reg;
  assign rx_full_irq = rxf_irq_reg;
  assign rx_error_irq = rxe_irq_reg;
  assign irq = irq_reg;

  // checks
  a_fmt_standby_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    standby_req |=> format_reg == `FORMAT_RESET) else $error("format not cleared");
  a_ctrl_standby_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    standby_req |=> ctrl_reg == `CTRL_RESET) else $error("control not cleared");
  a_fmt_write_takes: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wr_fmt && !standby_req |=> format_reg == $past(bus_req.data))
    else $error("format write lost");
  a_sync_no_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    load_pulse && format_reg.mode_sync |=> tx_state_reg == TX_DATA)
    else $error("sync frame has start");
  a_seven_bit_mask: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    load_pulse && !format_reg.mode_sync && format_reg.char_length_select |=>
    !tx_shifter[7]) else $error("bit 7 not dropped");
  a_five_bit_mask: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    load_pulse && !format_reg.mode_sync && format_reg.parity_enable &&
    format_reg.multiprocessor_enable |=> tx_shifter[7:5] == 3'h0)
    else $error("upper bits not dropped");
  a_sync_no_extra: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    tx_cfg_reg.mode_sync |-> tx_state_reg != TX_EXTRA && tx_state_reg != TX_STOP)
    else $error("sync frame has parity or stop");
  a_stop_line_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    $past(tx_state_reg) == TX_STOP |-> txd_reg) else $error("stop bit low");
  a_start_line_low: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    $past(tx_state_reg) == TX_START |-> !txd_reg) else $error("start bit high");
  a_rx_one_stop: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    rx_state_reg == RX_STOP && sample_tick_reg && rx_cnt_reg == `OVS_LAST &&
    !standby_req && !format_reg.mode_sync |=> rx_state_reg == RX_IDLE && rx_done_reg)
    else $error("receiver waits for second stop");
  a_txe_irq_follow: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    ##1 tx_empty_irq == $past(ctrl_reg[`CTRL_TIE] && tx_holding_empty_reg))
    else $error("tx empty irq wrong");
  a_rxf_irq_drop: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    !ctrl_reg[`CTRL_RIE] || (err_clr && !rx_holding_full_set) |=> !rx_full_irq)
    else $error("rx full irq stays");
  a_overrun_keeps: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    oer_set && !standby_req |=> oer_reg && $stable(rx_holding_reg))
    else $error("overrun mishandled");
  c_async_frame: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    tx_state_reg == TX_STOP ##1 tx_state_reg == TX_IDLE);
  c_rx_parity_err: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    rx_holding_full_set ##1 per_reg);
  c_sync_byte: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    format_reg.mode_sync && rx_holding_full_set);
  c_overrun: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg) oer_set);
endmodule

// ---- testbench/serial_peer.sv ----
// far-end serial peer that drives asynchronous frames onto the receive line
`timescale 1ns/10ps
module serial_peer (
  // clock
  input wire logic ref_clk,
  // line toward the unit
  output logic rxd
);
  initial rxd = 1'b1;
  // lsb first, 32 clocks a bit, line idles high between frames
  task send(input logic [23:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (32) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the serial unit
`timescale 1ns/10ps
`include "serial_map.svh"
module tb_top;
  import serial_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_type bus_req = '0;
  logic standby_req = 1'b0;
  logic sub_mode = 1'b0;
  logic sub_clk = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] r;
  logic rxd, txd, serial_clk_out, tx_empty_irq, rx_full_irq, rx_error_irq, irq;
  int n_errors = 0;
  int checked = 0;
  initial forever #4 ref_clk = ~ref_clk;
  initial forever #40 sub_clk = ~sub_clk;
  serial_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .standby_req(standby_req), .sub_mode(sub_mode), .sub_clk(sub_clk), .rxd(rxd), .txd(txd),
    .serial_clk_out(serial_clk_out), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .irq(irq));
  serial_peer peer (.ref_clk(ref_clk), .rxd(rxd));
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge ref_clk);
    bus_req <= '0;
    // read data stands until this edge replaces it
    @(posedge ref_clk);
    r = rd_data;
    chk(r, e);
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = txd;
      1: pick = serial_clk_out;
      2: pick = tx_empty_irq;
      default: pick = rx_full_irq;
    endcase
  endfunction
  task wait_for(input int s, input logic v);
    int k;
    k = 0;
    while (pick(s) !== v && k < 9000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 9000) chk(0, 1);
  endtask
  // frame after the start bit; returns its bit count
  function automatic int frame(input logic [7:0] f, input logic [7:0] d, input logic bad,
                               output logic [23:0] v);
    int n;
    logic [7:0] m;
    n = (f[5] & f[2]) ? 5 : (f[6] ? 7 : 8);
    m = d & ((8'h01 << n) - 8'h01);
    v = '1;
    v[7:0] = m | ~((8'h01 << n) - 8'h01);
    if (f[5] ^ f[2]) v[n] = f[5] & (^m ^ f[4] ^ bad);
    if (f[5] ^ f[2]) n++;
    return n + (f[3] ? 2 : 1);
  endfunction
  task regs;
    rc(`ADDR_FORMAT, 8'h00);
    rc(`ADDR_CTRL, 8'h00);
    rc(`ADDR_STATUS, 8'h84);
    rc(3'h7, 8'h00);
    wr(`ADDR_FORMAT, 8'hA5);
    wr(`ADDR_CTRL, 8'h3C);
    rc(`ADDR_FORMAT, 8'hA5);
    rc(`ADDR_CTRL, 8'h3C);
    standby_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    standby_req <= 1'b0;
    rc(`ADDR_FORMAT, 8'h00);
    rc(`ADDR_CTRL, 8'h00);
  endtask
  task tx_irq;
    wr(`ADDR_CTRL, 8'h80);
    wait_for(2, 1'b1);
    wr(`ADDR_TXDATA, 8'h11);
    wr(`ADDR_TXDATA, 8'h22);
    repeat (3) @(posedge ref_clk);
    chk(tx_empty_irq, 1'b0);
    wait_for(2, 1'b1);
    wr(`ADDR_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk(tx_empty_irq, 1'b0);
    repeat (700) @(posedge ref_clk);
  endtask
  task tx_frame(input logic [7:0] f);
    logic [23:0] e, g;
    int n;
    n = frame(f, 8'h53, 1'b0, e);
    g = '1;
    wr(`ADDR_FORMAT, f);
    wr(`ADDR_TXDATA, 8'h53);
    wait_for(0, 1'b0);
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (32) @(posedge ref_clk);
      g[i] = txd;
    end
    chk(g, e);
    repeat (32) @(posedge ref_clk);
  endtask
  task bit_len(input logic [7:0] f, input logic sm, input int e);
    int n;
    sub_mode <= sm;
    wr(`ADDR_FORMAT, f);
    wr(`ADDR_TXDATA, 8'hFD);
    // time the high data bit 0, bounded by two tick-aligned edges
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    n = 0;
    while (txd === 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(24'(n), 24'(e));
    repeat (11 * e) @(posedge ref_clk);
  endtask
  task sync_tx;
    logic [23:0] g;
    g = '0;
    wr(`ADDR_FORMAT, 8'hF8);
    wr(`ADDR_TXDATA, 8'hD3);
    for (int i = 0; i < 8; i++) begin
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      g[i] = txd;
    end
    chk(g, 24'h0000D3);
    repeat (64) @(posedge ref_clk);
    rc(`ADDR_RXDATA, 8'hFF);
    wr(`ADDR_STATUS, 8'h40);
  endtask
  task rx_path;
    logic [23:0] v;
    int n;
    wr(`ADDR_FORMAT, 8'h20);
    wr(`ADDR_CTRL, 8'h40);
    wr(`ADDR_MASK, 8'h40);
    for (int b = 0; b < 2; b++) begin
      n = frame(8'h20, 8'hA6, b[0], v);
      peer.send({v[22:0], 1'b0}, n + 1);
      wait_for(3, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b1);
      chk(rx_error_irq, b[0]);
      rc(`ADDR_RXDATA, 8'hA6);
      wr(`ADDR_STATUS, b[0] ? 8'h08 : 8'h40);
      repeat (2) @(posedge ref_clk);
      chk({rx_full_irq, rx_error_irq}, 2'b00);
    end
    wr(`ADDR_STATUS, 8'h40);
    wr(`ADDR_FORMAT, 8'h08);
    n = frame(8'h00, 8'h5A, 1'b0, v);
    peer.send({4'hF, v[8:0], 1'b0, v[8:0], 1'b0}, 20);
    repeat (4) @(posedge ref_clk);
    rc(`ADDR_STATUS, 8'hE4);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #600000;
    n_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    regs();
    $display("test regs done");
    tx_irq();
    $display("test tx_irq done");
    tx_frame(8'h00);
    tx_frame(8'h40);
    tx_frame(8'h20);
    tx_frame(8'h30);
    tx_frame(8'h08);
    tx_frame(8'h24);
    tx_frame(8'h04);
    $display("test tx_frame done");
    bit_len(8'h02, 1'b0, 512);
    bit_len(8'h03, 1'b0, 2048);
    bit_len(8'h01, 1'b0, 640);
    bit_len(8'h01, 1'b1, 320);
    $display("test bit_len done");
    sync_tx();
    $display("test sync_tx done");
    rx_path();
    $display("test rx_path done");
    results();
  end
endmodule
